// ### hw/hbd_regs.svh
// Register map, field layout, reset values and timing of the burnout monitor.
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH

// Register byte offsets.
`define HBD_OFF_CTRL     8'h00
`define HBD_OFF_THRESH   8'h04
`define HBD_OFF_FLOOR    8'h08
`define HBD_OFF_PERSIST  8'h0c
`define HBD_OFF_PHASE_R  8'h10
`define HBD_OFF_CYCLE_R  8'h14
`define HBD_OFF_TEACH    8'h18
`define HBD_OFF_STATUS   8'h1c
`define HBD_OFF_MASK     8'h20
`define HBD_OFF_PRESENT  8'h24
`define HBD_OFF_STATE    8'h28

// Field positions.
`define HBD_CTRL_ACTION  1:0
`define HBD_CTRL_METHOD  2
`define HBD_CTRL_SECOND  5:4
`define HBD_TEACH_PHASE  0
`define HBD_TEACH_CYCLE  1
`define HBD_ST_ALARM     0
`define HBD_ST_TEACH_OK  1
`define HBD_ST_TEACH_BAD 2
`define HBD_STATE_ALARM  0
`define HBD_STATE_LVL2   1
`define HBD_STATE_TCC_OK 2
`define HBD_STATE_COND   3
`define HBD_STATE_COUNT  25:16

// Reset values and limits.
`define HBD_THR_RST      7'h64
`define HBD_THR_MIN      7'h01
`define HBD_PCT_FULL     7'h64
`define HBD_FLOOR_RST    10'h000
`define HBD_FLOOR_MAX    10'h3e8
`define HBD_PERSIST_RST  10'h096
`define HBD_PERSIST_MAX  10'h3e7
`define HBD_RES_MAX      10'h3e7
`define HBD_SECOND_NOTCH 2'h3
`define HBD_ALARM_CODE   8'h40

// Teach current floor, in percent of the rated current.
`define HBD_TEACH_PCT    32'h0000_000a
`define HBD_PCT_INT      32'h0000_0064

// Alarm flash output half period.
`define HBD_FLASH_MS     32'h0000_01f4
`define HBD_CLK_KHZ      32'h0001_e848

`endif

// ### hw/hbd_pkg.sv
// Types shared by the heater burnout monitor.
package hbd_pkg;

  typedef enum logic [2:0] {
    HBD_IDLE  = 3'b001,
    HBD_DIV   = 3'b010,
    HBD_JUDGE = 3'b100
  } hbd_state_t;

  typedef enum logic [1:0] {
    HBD_ACT_OFF  = 2'h0,
    HBD_ACT_LVL1 = 2'h1,
    HBD_ACT_LVL2 = 2'h2
  } hbd_action_t;

endpackage

// ### hw/hbd_top.sv
// Heater burnout monitor: resistance estimate, judgment, teaching, alarms.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "hbd_regs.svh"

module hbd_top #(
  parameter int OUT_W         = 10,
  parameter int CUR_W         = 13,
  parameter int RATED_CURRENT = 2000,
  parameter int FLASH_CYCLES  = `HBD_FLASH_MS * `HBD_CLK_KHZ
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Register port.
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata_q,
  // Measurements from the power stage, on this clock.
  input  wire logic [OUT_W-1:0] output_value,
  input  wire logic [CUR_W-1:0] load_current,
  // Pins: power-line zero cross level and alarm reset input.
  input  wire logic             zero_cross_pin,
  input  wire logic             alarm_reset_pin,
  // Alarm outputs.
  output logic                  alarm_level1_q,
  output logic                  alarm_level2_q,
  output logic                  alarm_flash_q,
  output logic      [7:0]       burnout_alarm_code_q,
  output logic                  irq_q
);
  import hbd_pkg::*;

  localparam int RES_W = 10;
  localparam int NUM_W = OUT_W + 7;
  localparam int CNT_W = $clog2(NUM_W + 1);
  localparam int FL_W  = $clog2(FLASH_CYCLES + 1);
  localparam logic [CUR_W-1:0] TEACH_MIN =
    CUR_W'(RATED_CURRENT * `HBD_TEACH_PCT / `HBD_PCT_INT);

  // Output value is in 0.1 % steps up to 100.0 %, current in 0.01 A.
  generate
    if (OUT_W < 10 || CUR_W < 4 || CUR_W > 24 || RATED_CURRENT < 10) begin : g_chk
      $error("hbd_top: parameter values not supported");
    end
  endgenerate

  // Settings.
  hbd_action_t            action_q;
  logic                   method_q;
  logic [1:0]             second_q;
  logic [6:0]             thresh_q;
  logic [9:0]             floor_q;
  logic [9:0]             persist_q;
  logic [RES_W-1:0]       phase_r_q;
  logic [RES_W-1:0]       cycle_r_q;
  logic [2:0]             status_q;
  logic [2:0]             mask_q;

  // Pin synchronisers and filtered levels.
  logic [2:0]             zc_s_q;
  logic                   zc_lvl_q;
  logic [2:0]             ar_s_q;
  logic                   ar_lvl_q;
  logic                   half_tick;

  // Estimator and judgment.
  hbd_state_t             state_q;
  logic [NUM_W-1:0]       quo_q;
  logic [CUR_W:0]         rem_q;
  logic [CUR_W-1:0]       den_q;
  logic [CNT_W-1:0]       step_q;
  logic                   open_q;
  logic [OUT_W-1:0]       out_q;
  logic [RES_W-1:0]       est_q;
  logic [RES_W-1:0]       est_d;
  logic [CUR_W:0]         rem_sh;
  logic                   burn_cond;
  logic                   cond_q;
  logic [9:0]             count_q;
  logic [9:0]             count_inc;
  logic                   alarm_q;
  logic                   lvl2_q;
  logic [FL_W-1:0]        flash_cnt_q;

  // Decoded accesses and events.
  logic                   wr_ctrl;
  logic                   wr_thresh;
  logic                   wr_floor;
  logic                   wr_persist;
  logic                   wr_phase;
  logic                   wr_cycle;
  logic                   wr_teach;
  logic                   wr_mask;
  logic                   rd_status;
  logic                   teach_ph;
  logic                   teach_cy;
  logic                   tcc_avail;
  logic                   cur_ok;
  logic                   ev_alarm;
  logic [2:0]             status_d;
  logic [RES_W-1:0]       char_sel;
  logic [6:0]             gap;
  logic [RES_W+6:0]       lhs;
  logic [RES_W+6:0]       rhs;

  always_comb begin
    wr_ctrl    = 1'b0;
    wr_thresh  = 1'b0;
    wr_floor   = 1'b0;
    wr_persist = 1'b0;
    wr_phase   = 1'b0;
    wr_cycle   = 1'b0;
    wr_teach   = 1'b0;
    wr_mask    = 1'b0;
    if (reg_addr == `HBD_OFF_CTRL) begin
      wr_ctrl = reg_wr;
    end else if (reg_addr == `HBD_OFF_THRESH) begin
      wr_thresh = reg_wr;
    end else if (reg_addr == `HBD_OFF_FLOOR) begin
      wr_floor = reg_wr;
    end else if (reg_addr == `HBD_OFF_PERSIST) begin
      wr_persist = reg_wr;
    end else if (reg_addr == `HBD_OFF_PHASE_R) begin
      wr_phase = reg_wr;
    end else if (reg_addr == `HBD_OFF_CYCLE_R) begin
      wr_cycle = reg_wr;
    end else if (reg_addr == `HBD_OFF_TEACH) begin
      wr_teach = reg_wr;
    end else if (reg_addr == `HBD_OFF_MASK) begin
      wr_mask = reg_wr;
    end
  end

  assign rd_status = reg_rd && (reg_addr == `HBD_OFF_STATUS);
  assign tcc_avail = !(method_q && second_q == `HBD_SECOND_NOTCH);
  assign cur_ok    = load_current >= TEACH_MIN;
  assign teach_ph  = wr_teach && reg_wdata[`HBD_TEACH_PHASE];
  assign teach_cy  = wr_teach && reg_wdata[`HBD_TEACH_CYCLE] && tcc_avail;

  // Only the three listed action codes are taken; 3 leaves the setting.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      action_q <= HBD_ACT_OFF;
      method_q <= 1'b0;
      second_q <= 2'h0;
    end else if (wr_ctrl) begin
      if (reg_wdata[`HBD_CTRL_ACTION] != 2'h3) begin
        action_q <= hbd_action_t'(reg_wdata[`HBD_CTRL_ACTION]);
      end
      method_q <= reg_wdata[`HBD_CTRL_METHOD];
      second_q <= reg_wdata[`HBD_CTRL_SECOND];
    end
  end

  // Out of range writes are ignored so the judgment never sees them.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thresh_q  <= `HBD_THR_RST;
      floor_q   <= `HBD_FLOOR_RST;
      persist_q <= `HBD_PERSIST_RST;
      mask_q    <= 3'h0;
    end else begin
      if (wr_thresh && reg_wdata[31:7] == 25'h000_0000 &&
          reg_wdata[6:0] >= `HBD_THR_MIN &&
          reg_wdata[6:0] <= `HBD_PCT_FULL) begin
        thresh_q <= reg_wdata[6:0];
      end
      if (wr_floor && reg_wdata[31:10] == 22'h00_0000 &&
          reg_wdata[9:0] <= `HBD_FLOOR_MAX) begin
        floor_q <= reg_wdata[9:0];
      end
      if (wr_persist && reg_wdata[31:10] == 22'h00_0000 &&
          reg_wdata[9:0] <= `HBD_PERSIST_MAX) begin
        persist_q <= reg_wdata[9:0];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  // Characteristic values: direct write or teach from the last estimate.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r_q <= `HBD_RES_MAX;
      cycle_r_q <= `HBD_RES_MAX;
    end else begin
      if (wr_phase && reg_wdata[31:10] == 22'h00_0000 &&
          reg_wdata[9:0] <= `HBD_RES_MAX) begin
        phase_r_q <= reg_wdata[RES_W-1:0];
      end else if (teach_ph && cur_ok) begin
        phase_r_q <= est_q;
      end
      if (wr_cycle && reg_wdata[31:10] == 22'h00_0000 &&
          reg_wdata[9:0] <= `HBD_RES_MAX) begin
        cycle_r_q <= reg_wdata[RES_W-1:0];
      end else if (teach_cy && cur_ok) begin
        cycle_r_q <= est_q;
      end
    end
  end

  // Three-stage pin sampling; a level moves once stages two and three agree.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zc_s_q   <= 3'h0;
      zc_lvl_q <= 1'b0;
      ar_s_q   <= 3'h0;
      ar_lvl_q <= 1'b0;
    end else begin
      zc_s_q <= {zc_s_q[1:0], zero_cross_pin};
      ar_s_q <= {ar_s_q[1:0], alarm_reset_pin};
      if (zc_s_q[1] == zc_s_q[2]) begin
        zc_lvl_q <= zc_s_q[2];
      end
      if (ar_s_q[1] == ar_s_q[2]) begin
        ar_lvl_q <= ar_s_q[2];
      end
    end
  end

  // Each edge of the zero cross level starts one power half cycle.
  assign half_tick = (zc_s_q[1] == zc_s_q[2]) && (zc_s_q[2] != zc_lvl_q);

  // Estimate = 100 V * output / current, a serial divide per half cycle.
  // The supply voltage cancels, so no voltage measurement is needed.
  assign rem_sh = {rem_q[CUR_W-1:0], quo_q[NUM_W-1]};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= HBD_IDLE;
      quo_q   <= '0;
      rem_q   <= '0;
      den_q   <= '0;
      step_q  <= '0;
      open_q  <= 1'b0;
      out_q   <= '0;
    end else begin
      case (state_q)
        HBD_IDLE: begin
          if (half_tick) begin
            quo_q  <= NUM_W'(output_value) * NUM_W'(`HBD_PCT_FULL);
            rem_q  <= '0;
            den_q  <= load_current;
            out_q  <= output_value;
            step_q <= CNT_W'(NUM_W);
            open_q <= (load_current == '0);
            state_q <= (load_current == '0) ? HBD_JUDGE : HBD_DIV;
          end
        end
        HBD_DIV: begin
          if (rem_sh >= {1'b0, den_q}) begin
            rem_q <= rem_sh - {1'b0, den_q};
            quo_q <= {quo_q[NUM_W-2:0], 1'b1};
          end else begin
            rem_q <= rem_sh;
            quo_q <= {quo_q[NUM_W-2:0], 1'b0};
          end
          step_q <= step_q - CNT_W'(1);
          if (step_q == CNT_W'(1)) begin
            state_q <= HBD_JUDGE;
          end
        end
        HBD_JUDGE: begin
          state_q <= HBD_IDLE;
        end
        default: begin
          state_q <= HBD_IDLE;
        end
      endcase
    end
  end

  // A dead load or an estimate past the range reads as the top value.
  always_comb begin
    if (open_q || quo_q > NUM_W'(`HBD_RES_MAX)) begin
      est_d = `HBD_RES_MAX;
    end else begin
      est_d = quo_q[RES_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      est_q <= '0;
    end else if (state_q == HBD_JUDGE) begin
      est_q <= est_d;
    end
  end

  // Cross-multiplied form avoids dividing by (100 - threshold).
  assign char_sel = method_q ? cycle_r_q : phase_r_q;
  assign gap      = `HBD_PCT_FULL - thresh_q;
  assign lhs      = (RES_W+7)'(est_d) * (RES_W+7)'(gap);
  assign rhs      = (RES_W+7)'(char_sel) * (RES_W+7)'(`HBD_PCT_FULL);

  always_comb begin
    burn_cond = 1'b0;
    if (action_q != HBD_ACT_OFF && out_q >= floor_q) begin
      burn_cond = open_q || (lhs >= rhs);
    end
  end

  assign count_inc = (count_q == 10'h3ff) ? count_q : count_q + 10'h001;
  assign ev_alarm  = (state_q == HBD_JUDGE) && burn_cond && !alarm_q &&
                     (count_inc >= persist_q);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 10'h000;
      cond_q  <= 1'b0;
    end else if (state_q == HBD_JUDGE) begin
      cond_q <= burn_cond;
      if (burn_cond) begin
        count_q <= count_inc;
      end else begin
        count_q <= 10'h000;
      end
    end
  end

  // The alarm holds until the reset input, whatever the settings do after.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_q <= 1'b0;
      lvl2_q  <= 1'b0;
    end else if (ar_lvl_q) begin
      alarm_q <= 1'b0;
      lvl2_q  <= 1'b0;
    end else if (ev_alarm) begin
      alarm_q <= 1'b1;
      lvl2_q  <= (action_q == HBD_ACT_LVL2);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_cnt_q          <= '0;
      alarm_flash_q        <= 1'b0;
      alarm_level1_q       <= 1'b0;
      alarm_level2_q       <= 1'b0;
      burnout_alarm_code_q <= 8'h00;
    end else begin
      alarm_level1_q       <= alarm_q && !lvl2_q;
      alarm_level2_q       <= alarm_q && lvl2_q;
      burnout_alarm_code_q <= alarm_q ? `HBD_ALARM_CODE : 8'h00;
      if (!alarm_q) begin
        flash_cnt_q   <= '0;
        alarm_flash_q <= 1'b0;
      end else if (flash_cnt_q == FL_W'(FLASH_CYCLES - 1)) begin
        flash_cnt_q   <= '0;
        alarm_flash_q <= !alarm_flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + FL_W'(1);
      end
    end
  end

  // Sticky events; a set in the cycle of the clearing read survives.
  always_comb begin
    status_d = rd_status ? 3'h0 : status_q;
    status_d[`HBD_ST_ALARM] = status_d[`HBD_ST_ALARM] | ev_alarm;
    status_d[`HBD_ST_TEACH_OK] = status_d[`HBD_ST_TEACH_OK] |
      ((teach_ph || teach_cy) && cur_ok);
    status_d[`HBD_ST_TEACH_BAD] = status_d[`HBD_ST_TEACH_BAD] |
      (wr_teach && !cur_ok &&
       (reg_wdata[`HBD_TEACH_PHASE] || reg_wdata[`HBD_TEACH_CYCLE])) |
      (wr_teach && reg_wdata[`HBD_TEACH_CYCLE] && !tcc_avail);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= 3'h0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == `HBD_OFF_CTRL) begin
          reg_rdata_q[`HBD_CTRL_ACTION] <= action_q;
          reg_rdata_q[`HBD_CTRL_METHOD] <= method_q;
          reg_rdata_q[`HBD_CTRL_SECOND] <= second_q;
        end else if (reg_addr == `HBD_OFF_THRESH) begin
          reg_rdata_q[6:0] <= thresh_q;
        end else if (reg_addr == `HBD_OFF_FLOOR) begin
          reg_rdata_q[9:0] <= floor_q;
        end else if (reg_addr == `HBD_OFF_PERSIST) begin
          reg_rdata_q[9:0] <= persist_q;
        end else if (reg_addr == `HBD_OFF_PHASE_R) begin
          reg_rdata_q[RES_W-1:0] <= phase_r_q;
        end else if (reg_addr == `HBD_OFF_CYCLE_R) begin
          reg_rdata_q[RES_W-1:0] <= cycle_r_q;
        end else if (reg_addr == `HBD_OFF_STATUS) begin
          reg_rdata_q[2:0] <= status_q;
        end else if (reg_addr == `HBD_OFF_MASK) begin
          reg_rdata_q[2:0] <= mask_q;
        end else if (reg_addr == `HBD_OFF_PRESENT) begin
          reg_rdata_q[RES_W-1:0] <= est_q;
        end else if (reg_addr == `HBD_OFF_STATE) begin
          reg_rdata_q[`HBD_STATE_ALARM]  <= alarm_q;
          reg_rdata_q[`HBD_STATE_LVL2]   <= lvl2_q;
          reg_rdata_q[`HBD_STATE_TCC_OK] <= tcc_avail;
          reg_rdata_q[`HBD_STATE_COND]   <= cond_q;
          reg_rdata_q[`HBD_STATE_COUNT]  <= count_q;
        end
      end
    end
  end

endmodule

// ### tb/hbd_checker.sv
// Port-level assertions for the heater burnout monitor.
`timescale 1ns/1ps
module hbd_checker (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Register read side.
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  // Alarm side.
  input wire logic        alarm_reset_pin,
  input wire logic        alarm_level1_q,
  input wire logic        alarm_level2_q,
  input wire logic        alarm_flash_q,
  input wire logic [7:0]  burnout_alarm_code_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // The reset pin is filtered, so a held alarm is only sure to stay up once
  // the pin has been low for longer than the filter delay.
  sequence pin_quiet;
    (!alarm_reset_pin)[*6];
  endsequence
  sequence pin_held;
    alarm_reset_pin[*8];
  endsequence
  rd_idle_a:
    assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
    else $error("read data seen outside the answer cycle");
  level_excl_a:
    assert property (!(alarm_level1_q && alarm_level2_q))
    else $error("both alarm levels active together");
  alarm_code_a:
    assert property (burnout_alarm_code_q ==
      ((alarm_level1_q || alarm_level2_q) ? 8'h40 : 8'h00))
    else $error("alarm code does not follow the alarm");
  lvl1_latch_a:
    assert property (pin_quiet ##0 alarm_level1_q |=> alarm_level1_q)
    else $error("level 1 alarm dropped without the reset pin");
  lvl2_latch_a:
    assert property (pin_quiet ##0 alarm_level2_q |=> alarm_level2_q)
    else $error("level 2 alarm dropped without the reset pin");
  alarm_release_a:
    assert property ($fell(alarm_level1_q || alarm_level2_q) &&
      !$past(sys_rst) |-> $past(alarm_reset_pin, 2))
    else $error("alarm released while the reset pin was low");
  raise_block_a:
    assert property (pin_held |->
      !$rose(alarm_level1_q) && !$rose(alarm_level2_q))
    else $error("alarm raised while the reset pin was held");
  flash_period_a:
    assert property (pin_quiet ##0 $rose(alarm_flash_q) |->
      alarm_flash_q[*4])
    else $error("alarm flash high phase has the wrong length");
endmodule

bind hbd_top hbd_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .alarm_reset_pin(alarm_reset_pin), .alarm_level1_q(alarm_level1_q),
  .alarm_level2_q(alarm_level2_q), .alarm_flash_q(alarm_flash_q),
  .burnout_alarm_code_q(burnout_alarm_code_q));

// ### tb/hbd_tb_top.sv
// Directed bench for the heater burnout monitor.
`timescale 1ns/1ps
`include "hbd_regs.svh"
module hbd_tb_top;
  import hbd_pkg::*;
  logic        core_clk;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic [9:0]  output_value = 10'h000;
  logic [12:0] load_current = 13'h0000;
  logic        zero_cross_pin = 1'b0;
  logic        alarm_reset_pin = 1'b0;
  logic        alarm_level1_q;
  logic        alarm_level2_q;
  logic        alarm_flash_q;
  logic [7:0]  burnout_alarm_code_q;
  logic        irq_q;
  int          errors = 0;
  int          n_checks = 0;
  localparam logic [7:0] RO [11] = '{`HBD_OFF_CTRL, `HBD_OFF_THRESH,
    `HBD_OFF_FLOOR, `HBD_OFF_PERSIST, `HBD_OFF_PHASE_R, `HBD_OFF_CYCLE_R,
    `HBD_OFF_STATUS, `HBD_OFF_MASK, `HBD_OFF_PRESENT, `HBD_OFF_STATE, 8'h2c};
  localparam logic [31:0] RV [11] = '{32'h0000_0000, 32'h0000_0064,
    32'h0000_0000, 32'h0000_0096, 32'h0000_03e7, 32'h0000_03e7,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0004,
    32'h0000_0000};

  // A short flash period keeps the flashing visible within a few frames.
  hbd_top #(.FLASH_CYCLES(4)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .output_value(output_value),
    .load_current(load_current), .zero_cross_pin(zero_cross_pin),
    .alarm_reset_pin(alarm_reset_pin), .alarm_level1_q(alarm_level1_q),
    .alarm_level2_q(alarm_level2_q), .alarm_flash_q(alarm_flash_q),
    .burnout_alarm_code_q(burnout_alarm_code_q), .irq_q(irq_q));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  // Each access leaves one idle cycle so a strobe is never lowered and
  // raised again in the same time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Read data stand only until the next edge, so look at them now.
    #1;
    chk(reg_rdata_q & m, e);
    @(posedge core_clk);
  endtask

  // One power half cycle; the gap is wider than the judgment latency.
  task automatic hc(input logic [9:0] ov, input logic [12:0] cur);
    output_value <= ov;
    load_current <= cur;
    zero_cross_pin <= ~zero_cross_pin;
    repeat (30) @(posedge core_clk);
    #1;
  endtask

  task automatic al(input logic [1:0] lv);
    chk({22'h0, alarm_level2_q, alarm_level1_q, burnout_alarm_code_q},
        {22'h0, lv, (lv != 2'b00) ? 8'h40 : 8'h00});
  endtask

  task automatic clr;
    alarm_reset_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    alarm_reset_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, irq_q}, {31'h0, v});
  endtask

  function automatic logic [31:0] ctrl(logic m, logic [1:0] s,
                                       hbd_action_t a);
    return {26'h0, s, 1'b0, m, a};
  endfunction

  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 11; i++) rd(RO[i], RV[i]);
    wr(`HBD_OFF_THRESH, 7'h00);
    wr(`HBD_OFF_THRESH, 7'h65);
    rd(`HBD_OFF_THRESH, 7'h64);
    wr(`HBD_OFF_THRESH, 7'h01);
    rd(`HBD_OFF_THRESH, 7'h01);
    wr(`HBD_OFF_PERSIST, 10'h3e8);
    rd(`HBD_OFF_PERSIST, 10'h096);
    wr(`HBD_OFF_FLOOR, 10'h3e9);
    rd(`HBD_OFF_FLOOR, 10'h000);
    wr(`HBD_OFF_PHASE_R, 10'h3e8);
    rd(`HBD_OFF_PHASE_R, 10'h3e7);
    wr(`HBD_OFF_CYCLE_R, 10'h000);
    rd(`HBD_OFF_CYCLE_R, 10'h000);
    wr(`HBD_OFF_CTRL, 2'h3);
    rd(`HBD_OFF_CTRL, 2'h0);
    wr(`HBD_OFF_MASK, 3'h7);
    hc(10'h3e8, 13'h03e8);
    rd(`HBD_OFF_PRESENT, 10'h064);
    hc(10'h3e8, 13'h0000);
    rd(`HBD_OFF_PRESENT, 10'h3e7);
    rd(`HBD_OFF_STATE, 4'h0, 32'h03ff_0008);
    hc(10'h3e8, 13'h03e8);
    // Teaching just below and at the rated current floor.
    load_current <= 13'h00c7;
    wr(`HBD_OFF_TEACH, 2'h1);
    irq_is(1'b1);
    rd(`HBD_OFF_STATUS, 3'h4);
    irq_is(1'b0);
    rd(`HBD_OFF_PHASE_R, 10'h3e7);
    load_current <= 13'h00c8;
    wr(`HBD_OFF_TEACH, 2'h1);
    rd(`HBD_OFF_STATUS, 3'h2);
    rd(`HBD_OFF_PHASE_R, 10'h064);
    wr(`HBD_OFF_CTRL, ctrl(1'b1, 2'h3, HBD_ACT_OFF));
    rd(`HBD_OFF_STATE, 4'h0, 4'h4);
    wr(`HBD_OFF_TEACH, 2'h2);
    rd(`HBD_OFF_STATUS, 3'h4);
    rd(`HBD_OFF_CYCLE_R, 10'h000);
    for (int s = 0; s < 3; s++) begin
      wr(`HBD_OFF_CTRL, ctrl(1'b1, s[1:0], HBD_ACT_OFF));
      rd(`HBD_OFF_STATE, 4'h4, 4'h4);
    end
    wr(`HBD_OFF_TEACH, 2'h2);
    rd(`HBD_OFF_STATUS, 3'h2);
    rd(`HBD_OFF_CYCLE_R, 10'h064);
    // Cycle control judges against its own, larger value.
    wr(`HBD_OFF_CYCLE_R, 10'h190);
    wr(`HBD_OFF_THRESH, 7'h32);
    wr(`HBD_OFF_PERSIST, 10'h000);
    wr(`HBD_OFF_CTRL, ctrl(1'b1, 2'h0, HBD_ACT_LVL1));
    hc(10'h3e8, 13'h01f4);
    rd(`HBD_OFF_STATE, 4'h0, 4'hb);
    wr(`HBD_OFF_CTRL, ctrl(1'b0, 2'h0, HBD_ACT_LVL1));
    wr(`HBD_OFF_FLOOR, 10'h258);
    hc(10'h257, 13'h00fa);
    rd(`HBD_OFF_STATE, 4'h0, 4'hb);
    hc(10'h258, 13'h012c);
    rd(`HBD_OFF_STATE, 32'h0001_0009, 32'h03ff_000b);
    al(2'b01);
    rd(`HBD_OFF_STATUS, 3'h1, 3'h1);
    clr;
    al(2'b00);
    wr(`HBD_OFF_FLOOR, 10'h000);
    wr(`HBD_OFF_PERSIST, 10'h003);
    wr(`HBD_OFF_CTRL, ctrl(1'b0, 2'h0, HBD_ACT_LVL2));
    hc(10'h3e8, 13'h01f4);
    hc(10'h3e3, 13'h01f4);
    rd(`HBD_OFF_STATE, 4'h0, 32'h03ff_0008);
    hc(10'h3e8, 13'h01f4);
    hc(10'h3e8, 13'h01f4);
    rd(`HBD_OFF_STATE, 32'h0002_0008, 32'h03ff_000b);
    al(2'b00);
    hc(10'h3e8, 13'h01f4);
    al(2'b10);
    hc(10'h3e8, 13'h03e8);
    rd(`HBD_OFF_STATE, 4'h3, 32'h03ff_000b);
    al(2'b10);
    clr;
    al(2'b00);
    wr(`HBD_OFF_THRESH, 7'h64);
    hc(10'h3e8, 13'h0064);
    rd(`HBD_OFF_STATE, 4'h0, 4'h8);
    hc(10'h3e8, 13'h0000);
    rd(`HBD_OFF_STATE, 4'h8, 4'h8);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule
